/* File: rtl/cpd_top.sv */
// Purpose: Command pulse input decoder with AXI4-Lite registers
// Assumes: link_clk free running, pins and probes asynchronous
// Notes: Selectors take effect at reset or after a restart write
//
// Function
// R1: Invert setting reverses rotation against command sign
// R2: Host polarity applies only while invert is clear
// R3: Control mode nine makes selector probe polarity
// R4: Otherwise selector picks quadrature, dual, step-dir
// R5: Dual trains count forward and reverse oppositely
// R6: Selectors latch only at reset or restart
`timescale 1ns/1ps
`default_nettype none
module cpd_top #(
    parameter int CW = 16
) (
    // Clocks and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic link_clk,
    // Pulse and probe pins
    input wire logic pulse_a,
    input wire logic pulse_b,
    input wire logic probe1_in,
    input wire logic probe2_in,
    // AXI4-Lite write
    input wire logic [cpd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [cpd_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Motion and probe outputs
    output logic step_pulse,
    output logic step_dir,
    output logic [CW-1:0] position,
    output logic probe1_out,
    output logic probe2_out
);
    import cpd_pkg::*;

    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    function automatic logic [CW-1:0] gray2bin(input logic [CW-1:0] g);
        logic [CW-1:0] b;
        b[CW-1] = g[CW-1];
        for (int i = CW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    cpd_step_if #(.CW(CW)) link_if ();

    cpd_decoder #(.CW(CW)) u_dec (
        .link_clk(link_clk),
        .pulse_a(pulse_a),
        .pulse_b(pulse_b),
        .lnk(link_if.dec)
    );

    logic [CW-1:0] gray_s, bin, delta;
    logic [1:0] probe_s;

    cpd_sync2 #(.W(CW)) u_gsync (
        .clk(aclk),
        .rst_n(aresetn),
        .din(link_if.gray),
        .dout(gray_s)
    );

    cpd_sync2 #(.W(2)) u_psync (
        .clk(aclk),
        .rst_n(aresetn),
        .din({probe2_in, probe1_in}),
        .dout(probe_s)
    );

    // Bus channel state
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic aw_hs, w_hs, b_hs, ar_hs, r_hs, do_write;
    logic [15:0] widx, ridx;

    // Software registers and latched selectors
    logic [15:0] mode_reg_q, mode_reg_d, inv_reg_q, inv_reg_d;
    logic [15:0] sel_reg_q, sel_reg_d, hpol_reg_q, hpol_reg_d;
    logic inv_l_q, inv_l_d, mode9_l_q, mode9_l_d;
    logic [1:0] sel_l_q, sel_l_d;
    logic [5:0] hold_q, hold_d;
    logic run_q, run_d, restart_req, wr_ok;

    // Output state
    logic [CW-1:0] prev_q, prev_d, pos_q, pos_d;
    logic step_q, step_d, dir_q, dir_d, p1_q, p1_d, p2_q, p2_d;
    logic inv1, inv2;

    assign aw_hs = s_axi_awvalid & awready_q;
    assign w_hs = s_axi_wvalid & wready_q;
    assign b_hs = bvalid_q & s_axi_bready;
    assign ar_hs = s_axi_arvalid & arready_q;
    assign r_hs = rvalid_q & s_axi_rready;
    assign do_write = aw_full_q & w_full_q & ~bvalid_q;
    assign widx = awaddr_q[ADDR_W-1:2];
    assign ridx = s_axi_araddr[ADDR_W-1:2];

    always_comb begin
        aw_full_d = aw_full_q;
        awaddr_d = awaddr_q;
        w_full_d = w_full_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (aw_hs) begin
            aw_full_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (w_hs) begin
            w_full_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (do_write) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (b_hs) begin
            bvalid_d = 1'b0;
        end
        awready_d = ~aw_full_d & ~bvalid_d;
        wready_d = ~w_full_d & ~bvalid_d;
    end

    always_comb begin
        mode_reg_d = mode_reg_q;
        inv_reg_d = inv_reg_q;
        sel_reg_d = sel_reg_q;
        hpol_reg_d = hpol_reg_q;
        restart_req = 1'b0;
        wr_ok = 1'b1;
        case (widx)
            IDX_CTRL_MODE: mode_reg_d = merge16(mode_reg_q, wdata_q, wstrb_q);
            IDX_CMD_INV: inv_reg_d = merge16(inv_reg_q, wdata_q, wstrb_q);
            IDX_SEL: sel_reg_d = merge16(sel_reg_q, wdata_q, wstrb_q);
            IDX_HOST_POL: hpol_reg_d = merge16(hpol_reg_q, wdata_q, wstrb_q);
            IDX_RESTART: restart_req = do_write & wstrb_q[0] & wdata_q[0];
            IDX_POSITION, IDX_STATUS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
        if (!do_write) begin
            mode_reg_d = mode_reg_q;
            inv_reg_d = inv_reg_q;
            sel_reg_d = sel_reg_q;
            hpol_reg_d = hpol_reg_q;
        end
    end

    // Written selectors reach the decoder only through a restart; host polarity goes straight through
    always_comb begin
        inv_l_d = inv_l_q;
        sel_l_d = sel_l_q;
        mode9_l_d = mode9_l_q;
        hold_d = (hold_q != 6'h00) ? hold_q - 6'h01 : hold_q;
        if (restart_req) begin // see R6
            inv_l_d = inv_reg_q[0];
            sel_l_d = sel_reg_q[1:0];
            mode9_l_d = (mode_reg_q == PROBE_MODE);
            hold_d = RESTART_CYC;
        end
        run_d = (hold_d == 6'h00);
    end

    assign bin = gray2bin(gray_s);
    assign delta = bin - prev_q;
    assign inv1 = (sel_l_q == SEL_QUAD_A) | (sel_l_q == SEL_QUAD_B);
    assign inv2 = (sel_l_q == SEL_QUAD_A) | (sel_l_q == SEL_DUAL);

    always_comb begin
        prev_d = bin;
        pos_d = bin;
        step_d = run_q & (delta != '0);
        dir_d = step_d ? delta[CW-1] : dir_q;
        p1_d = probe_s[0] ^ (mode9_l_q & inv1); // see R3
        p2_d = probe_s[1] ^ (mode9_l_q & inv2); // see R3
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (ar_hs) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            case (ridx)
                IDX_CTRL_MODE: rdata_d = {16'h0000, mode_reg_q};
                IDX_CMD_INV: rdata_d = {16'h0000, inv_reg_q};
                IDX_SEL: rdata_d = {16'h0000, sel_reg_q};
                IDX_HOST_POL: rdata_d = {16'h0000, hpol_reg_q};
                IDX_RESTART: rdata_d = 32'h0000_0000;
                IDX_POSITION: rdata_d = 32'(pos_q);
                IDX_STATUS: rdata_d = {27'h000_0000, run_q, mode9_l_q,
                    sel_l_q, inv_l_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        if (r_hs) begin
            rvalid_d = 1'b0;
        end
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
            mode_reg_q <= RST_CTRL_MODE;
            inv_reg_q <= RST_CMD_INV;
            sel_reg_q <= RST_SEL;
            hpol_reg_q <= RST_HOST_POL;
            inv_l_q <= RST_CMD_INV[0];
            sel_l_q <= RST_SEL[1:0];
            mode9_l_q <= (RST_CTRL_MODE == PROBE_MODE);
            hold_q <= RESTART_CYC;
            run_q <= 1'b0;
            prev_q <= '0;
            pos_q <= '0;
            step_q <= 1'b0;
            dir_q <= 1'b0;
            p1_q <= 1'b0;
            p2_q <= 1'b0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            mode_reg_q <= mode_reg_d;
            inv_reg_q <= inv_reg_d;
            sel_reg_q <= sel_reg_d;
            hpol_reg_q <= hpol_reg_d;
            inv_l_q <= inv_l_d;
            sel_l_q <= sel_l_d;
            mode9_l_q <= mode9_l_d;
            hold_q <= hold_d;
            run_q <= run_d;
            prev_q <= prev_d;
            pos_q <= pos_d;
            step_q <= step_d;
            dir_q <= dir_d;
            p1_q <= p1_d;
            p2_q <= p2_d;
        end
    end

    assign link_if.run = run_q;
    assign link_if.mode9 = mode9_l_q;
    assign link_if.sel = sel_l_q;
    assign link_if.dir_inv = inv_l_q;
    assign link_if.host_pol = hpol_reg_q[0];

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign step_pulse = step_q;
    assign step_dir = dir_q;
    assign position = pos_q;
    assign probe1_out = p1_q;
    assign probe2_out = p2_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    latch_hold_a: assert property (!restart_req |=> $stable(sel_l_q) &&
        $stable(inv_l_q) && $stable(mode9_l_q)) // see R6
        else $error("selector changed without restart");
    restart_run_a: assert property (restart_req |=> !run_q [*8]) // see R6
        else $error("decoder not held after restart");
    probe_both_a: assert property ((mode9_l_q && sel_l_q == SEL_QUAD_A)
        |=> probe1_out != $past(probe_s[0]) &&
        probe2_out != $past(probe_s[1])) // see R3
        else $error("probe inversion wrong for selector zero");
    probe_none_a: assert property ((mode9_l_q && sel_l_q == SEL_STEP_DIR)
        |=> probe1_out == $past(probe_s[0]) &&
        probe2_out == $past(probe_s[1])) // see R3
        else $error("probe changed for selector three");

    cover property (restart_req);
    cover property (step_q && dir_q);
    cover property (step_q && !dir_q);
endmodule
`default_nettype wire

/* File: rtl/cpd_pkg.sv */
// Purpose: Shared constants for the command pulse input decoder
// Assumes: 25 MHz register clock, AXI4-Lite word registers
// Notes: Register addresses are indices; byte address is index times four
package cpd_pkg;
    localparam int ADDR_W = 18;
    localparam int CLK_PERIOD_NS = 40;

    // Register indices
    localparam logic [15:0] IDX_CTRL_MODE = 16'h2001;
    localparam logic [15:0] IDX_CMD_INV = 16'h2006;
    localparam logic [15:0] IDX_SEL = 16'h2007;
    localparam logic [15:0] IDX_RESTART = 16'h2100;
    localparam logic [15:0] IDX_HOST_POL = 16'h2101;
    localparam logic [15:0] IDX_POSITION = 16'h2102;
    localparam logic [15:0] IDX_STATUS = 16'h2103;

    // Values after reset
    localparam logic [15:0] RST_CTRL_MODE = 16'h0000;
    localparam logic [15:0] RST_CMD_INV = 16'h0000;
    localparam logic [15:0] RST_SEL = 16'h0003;
    localparam logic [15:0] RST_HOST_POL = 16'h0000;

    // Control mode value that turns the selector into probe polarity
    localparam logic [15:0] PROBE_MODE = 16'h0009;

    // Selector encodings
    localparam logic [1:0] SEL_QUAD_A = 2'h0;
    localparam logic [1:0] SEL_DUAL = 2'h1;
    localparam logic [1:0] SEL_QUAD_B = 2'h2;
    localparam logic [1:0] SEL_STEP_DIR = 2'h3;

    // Restart hold time and its cycle count (rounded up)
    localparam int RESTART_NS = 1280;
    localparam int RESTART_CYC_I = (RESTART_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam logic [5:0] RESTART_CYC = 6'(RESTART_CYC_I);

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/cpd_step_if.sv */
// Purpose: Carrier between register side and link-side decoder
// Assumes: Config lines are quasi-static levels, gray is a gray count
// Notes: Each side resynchronises what it receives
`timescale 1ns/1ps
`default_nettype none
interface cpd_step_if #(parameter int CW = 16);
    logic run;
    logic mode9;
    logic dir_inv;
    logic host_pol;
    logic [1:0] sel;
    logic [CW-1:0] gray;
    modport ctl(output run, mode9, dir_inv, host_pol, sel, input gray);
    modport dec(input run, mode9, dir_inv, host_pol, sel, output gray);
endinterface
`default_nettype wire

/* File: rtl/cpd_sync2.sv */
// Purpose: Two flip-flop level synchroniser
// Assumes: Multi-bit inputs are gray coded or static while sampled
// Notes: First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module cpd_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q, meta_d, sync_q, sync_d;

    always_comb begin
        meta_d = din;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;
endmodule
`default_nettype wire

/* File: rtl/cpd_decoder.sv */
// Purpose: Link-clock pulse decoder producing a gray-coded step count
// Assumes: Pulse pins are asynchronous to link_clk
// Notes: Held in reset while the register side is restarting
`timescale 1ns/1ps
`default_nettype none
module cpd_decoder #(
    parameter int CW = 16
) (
    // Link clock
    input wire logic link_clk,
    // Pulse pins
    input wire logic pulse_a,
    input wire logic pulse_b,
    // Register side
    cpd_step_if.dec lnk
);
    import cpd_pkg::*;

    logic [5:0] cfg_raw, cfg_s;
    logic lrun, mode9, inv, hpol, eff_inv;
    logic [1:0] sel, ab_s;
    logic [1:0] prev_q, prev_d;
    logic [CW-1:0] cnt_q, cnt_d, gray_q, gray_d;
    logic up, dn, fwd, rise_a, rise_b, one_chg;

    assign cfg_raw = {lnk.run, lnk.mode9, lnk.sel, lnk.dir_inv,
        lnk.host_pol};

    cpd_sync2 #(.W(6)) u_cfg (
        .clk(link_clk),
        .rst_n(1'b1),
        .din(cfg_raw),
        .dout(cfg_s)
    );

    assign lrun = cfg_s[5];
    assign mode9 = cfg_s[4];
    assign sel = cfg_s[3:2];
    assign inv = cfg_s[1];
    assign hpol = cfg_s[0];
    // Host polarity only counts while the invert setting is clear
    assign eff_inv = inv | hpol; // see R2

    cpd_sync2 #(.W(2)) u_pin (
        .clk(link_clk),
        .rst_n(lrun),
        .din({pulse_a, pulse_b}),
        .dout(ab_s)
    );

    assign rise_a = ab_s[1] & ~prev_q[1];
    assign rise_b = ab_s[0] & ~prev_q[0];
    assign one_chg = (ab_s[1] ^ prev_q[1]) ^ (ab_s[0] ^ prev_q[0]);

    always_comb begin
        fwd = 1'b0;
        dn = 1'b0;
        if (!mode9) begin // see R3
            case (sel) // see R4
                SEL_DUAL: begin
                    // Simultaneous edges on both lines cancel
                    fwd = rise_a & ~rise_b; // see R5
                    dn = rise_b & ~rise_a; // see R5
                end
                SEL_STEP_DIR: begin
                    fwd = rise_a & ~ab_s[0];
                    dn = rise_a & ab_s[0];
                end
                default: begin
                    // A leading B counts forward; double changes dropped
                    fwd = one_chg & (ab_s[1] ^ prev_q[0]);
                    dn = one_chg & ~(ab_s[1] ^ prev_q[0]);
                end
            endcase
        end else begin
            dn = 1'b0;
        end
        up = eff_inv ? dn : fwd; // see R1
        dn = eff_inv ? fwd : dn; // see R1
        if (up) begin
            cnt_d = cnt_q + CW'(1);
        end else if (dn) begin
            cnt_d = cnt_q - CW'(1);
        end else begin
            cnt_d = cnt_q;
        end
        prev_d = ab_s;
        gray_d = cnt_d ^ (cnt_d >> 1);
    end

    always_ff @(posedge link_clk) begin
        if (!lrun) begin
            prev_q <= 2'h0;
            cnt_q <= '0;
            gray_q <= '0;
        end else begin
            prev_q <= prev_d;
            cnt_q <= cnt_d;
            gray_q <= gray_d;
        end
    end

    assign lnk.gray = gray_q;

    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!lrun);

    quad_fwd_a: assert property ((!mode9 && (sel == SEL_QUAD_A ||
        sel == SEL_QUAD_B) && prev_q == 2'h0 && ab_s == 2'h2 && !eff_inv)
        |=> cnt_q == $past(cnt_q) + CW'(1)) // see R4
        else $error("quadrature forward edge did not count up");
    dual_cw_a: assert property ((!mode9 && sel == SEL_DUAL && rise_a &&
        !rise_b && !eff_inv) |=> cnt_q == $past(cnt_q) + CW'(1)) // see R5
        else $error("cw pulse did not count up");
    dual_ccw_a: assert property ((!mode9 && sel == SEL_DUAL && rise_b &&
        !rise_a && !eff_inv) |=> cnt_q == $past(cnt_q) - CW'(1)) // see R5
        else $error("ccw pulse did not count down");
    dir_inv_a: assert property ((!mode9 && sel == SEL_STEP_DIR && rise_a &&
        !ab_s[0] && inv) |=> cnt_q == $past(cnt_q) - CW'(1)) // see R1
        else $error("inverted step did not count down");
    host_pol_a: assert property ((!mode9 && sel == SEL_DUAL && rise_a &&
        !rise_b && !inv && hpol) |=> cnt_q == $past(cnt_q) - CW'(1))
        // see R2
        else $error("host polarity not applied");
    probe_idle_a: assert property (mode9 |=> $stable(cnt_q)) // see R3
        else $error("count moved in probe mode");
    cover property (!mode9 && sel == SEL_DUAL && rise_b);
endmodule
`default_nettype wire

/* File: testbench/cpd_pulse_src.sv */
// Purpose: Motion controller model driving the command pulse lines
// Assumes: Push-pull lines, idle low, levels held HOLD link clocks
// Notes: kind 0/1 quad fwd/rev, 2 line A, 3 line B, 4 step with dir high
`timescale 1ns/1ps
`default_nettype none
module cpd_pulse_src #(
    parameter int NP = 3,
    parameter int HOLD = 4
) (
    // Link clock
    input wire logic link_clk,
    // Request from bench
    input wire logic go,
    input wire logic [2:0] kind,
    output logic done,
    // Pulse lines
    output logic pa,
    output logic pb
);
    task automatic lv(input logic a, input logic b);
        pa = a;
        pb = b;
        repeat (HOLD) @(negedge link_clk);
    endtask
    initial begin
        pa = 1'h0;
        pb = 1'h0;
        done = 1'h0;
        forever begin
            wait (go);
            @(negedge link_clk);
            for (int i = 0; i < NP; i++) begin
                case (kind)
                    3'h0: begin
                        lv(1'h1, 1'h0);
                        lv(1'h1, 1'h1);
                        lv(1'h0, 1'h1);
                        lv(1'h0, 1'h0);
                    end
                    3'h1: begin
                        lv(1'h0, 1'h1);
                        lv(1'h1, 1'h1);
                        lv(1'h1, 1'h0);
                        lv(1'h0, 1'h0);
                    end
                    3'h2: begin
                        lv(1'h1, 1'h0);
                        lv(1'h0, 1'h0);
                    end
                    3'h3: begin
                        lv(1'h0, 1'h1);
                        lv(1'h0, 1'h0);
                    end
                    default: begin
                        lv(1'h0, 1'h1);
                        lv(1'h1, 1'h1);
                        lv(1'h0, 1'h1);
                    end
                endcase
            end
            lv(1'h0, 1'h0);
            done = 1'h1;
            wait (!go);
            done = 1'h0;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the command pulse input decoder
// Assumes: AXI4-Lite master tasks, pulse source on the link clock
// Notes: Table rows first, then probes, bus errors and a second reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cpd_pkg::*;
    typedef struct {
        logic [15:0] mode;
        logic inv;
        logic hp;
        logic [1:0] sel;
        logic [1:0] sel2;
        logic [2:0] kind;
        int mul;
    } cpd_row_t;
    localparam int NP = 3;
    cpd_row_t rows [12] = '{
        '{16'h0000, 1'h0, 1'h0, 2'h0, 2'h0, 3'h0, 4},
        '{16'h0000, 1'h0, 1'h0, 2'h2, 2'h2, 3'h1, -4},
        '{16'h0000, 1'h1, 1'h0, 2'h0, 2'h0, 3'h0, -4},
        '{16'h0000, 1'h0, 1'h0, 2'h1, 2'h1, 3'h2, 1},
        '{16'h0000, 1'h0, 1'h0, 2'h1, 2'h1, 3'h3, -1},
        '{16'h0000, 1'h1, 1'h0, 2'h1, 2'h1, 3'h2, -1},
        '{16'h0000, 1'h0, 1'h0, 2'h3, 2'h3, 3'h2, 1},
        '{16'h0000, 1'h0, 1'h0, 2'h3, 2'h3, 3'h4, -1},
        '{16'h0000, 1'h0, 1'h1, 2'h1, 2'h1, 3'h2, -1},
        '{16'h0000, 1'h1, 1'h1, 2'h3, 2'h3, 3'h2, -1},
        '{16'h0009, 1'h0, 1'h0, 2'h3, 2'h3, 3'h2, 0},
        '{16'h0000, 1'h0, 1'h0, 2'h3, 2'h1, 3'h3, 0}
    };
    logic [15:0] ri [4] = '{IDX_CTRL_MODE, IDX_CMD_INV, IDX_SEL, IDX_HOST_POL};
    logic [15:0] rv0 [4] = '{RST_CTRL_MODE, RST_CMD_INV, RST_SEL, RST_HOST_POL};
    logic aclk = 1'h0;
    logic aresetn, link_clk, go, pa, pb, done, p1, p2, q1, q2;
    logic awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr, stp, sdir;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic [2:0] kind;
    logic [15:0] pos;
    int n_errors, compares, cyc, steps, s0, e;

    cpd_top #(.CW(16)) uut (.aclk(aclk), .aresetn(aresetn),
        .link_clk(link_clk), .pulse_a(pa), .pulse_b(pb), .probe1_in(p1),
        .probe2_in(p2), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .step_pulse(stp), .step_dir(sdir), .position(pos),
        .probe1_out(q1), .probe2_out(q2));
    cpd_pulse_src #(.NP(NP), .HOLD(4)) src (.link_clk(link_clk), .go(go),
        .kind(kind), .done(done), .pa(pa), .pb(pb));

    always #20 aclk = ~aclk;
    initial begin
        link_clk = 1'h0;
        #17;
        forever #62.5 link_clk = ~link_clk;
    end

    task automatic wrap_up();
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (stp === 1'h1) steps <= steps + 1;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] x, logic [31:0] g);
        compares++;
        if (g !== x) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
            n_errors++;
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        do begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'h0;
            if (wv && wr_r) wv <= 1'h0;
        end while (!(bv === 1'h1 && br));
        rs = bresp;
        br <= 1'h0;
    endtask

    task automatic rdr(input logic [15:0] idx);
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arv <= 1'h1;
        rr <= 1'h1;
        do begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'h0;
        end while (!(rv === 1'h1 && rr));
        rd = rdata;
        rs = rresp;
        rr <= 1'h0;
    endtask

    task automatic restart();
        wr(IDX_RESTART, 32'h0000_0001);
        repeat (60) @(posedge aclk);
    endtask

    initial begin
        {aresetn, go, kind, p1, p2, awv, wv, br, arv, rr} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (60) @(posedge aclk);
        foreach (rows[i]) begin
            wr(IDX_CTRL_MODE, {16'h0000, rows[i].mode});
            wr(IDX_CMD_INV, {31'h0, rows[i].inv});
            wr(IDX_HOST_POL, {31'h0, rows[i].hp});
            wr(IDX_SEL, {30'h0, rows[i].sel});
            restart();
            chk("position_clear", 32'h0000_0000, {16'h0000, pos});
            wr(IDX_SEL, {30'h0, rows[i].sel2});
            s0 = steps;
            @(posedge aclk);
            kind <= rows[i].kind;
            go <= 1'h1;
            do @(posedge aclk); while (done !== 1'h1);
            go <= 1'h0;
            repeat (20) @(posedge aclk);
            e = rows[i].mul * NP;
            chk("position", {16'h0000, e[15:0]}, {16'h0000, pos});
            rdr(IDX_POSITION);
            chk("position_reg", {16'h0000, e[15:0]}, rd);
            chk("steps", (e < 0) ? -e : e, steps - s0);
            if (e != 0) chk("step_dir", {31'h0, e < 0}, {31'h0, sdir});
        end
        wr(IDX_CTRL_MODE, {16'h0000, PROBE_MODE});
        @(posedge aclk);
        p1 <= 1'h1;
        for (int s = 0; s < 4; s++) begin
            wr(IDX_SEL, s);
            restart();
            chk("probe1", {31'h0, !(s == 0 || s == 2)}, {31'h0, q1});
            chk("probe2", {31'h0, s == 0 || s == 1}, {31'h0, q2});
        end
        wr(16'h2000, 32'h0000_00aa);
        chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        rdr(16'h2000);
        chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        chk("rdata", 32'h0000_0000, rd);
        wr(IDX_CMD_INV, 32'h0000_0001);
        wr(IDX_HOST_POL, 32'h0000_0001);
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        foreach (ri[k]) begin
            rdr(ri[k]);
            chk("reset_value", {16'h0000, rv0[k]}, rd);
            chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
        end
        wrap_up();
    end
endmodule
`default_nettype wire
